// ### rch_core.sv
// Command interpreter, register file, ports and host/GPIO pins
`timescale 1ns/1ps
module rch_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_valid,
  input wire logic [7:0] link_byte,
  input wire logic link_last,
  output logic link_rd_valid,
  output logic [7:0] link_rd_byte,
  input wire logic host_select_n,
  input wire logic host_write_not_read,
  input wire logic host_data_not_address,
  input wire logic host_strobe,
  input wire logic [7:0] host_bus_lines_in,
  output logic [7:0] host_bus_lines_out,
  output logic [7:0] host_bus_lines_oe,
  output logic host_irq_n,
  output logic port_wr_valid,
  output logic [1:0] port_wr_sel,
  output logic [7:0] port_wr_byte,
  output logic port_rd_req,
  output logic [1:0] port_rd_sel,
  input wire logic [7:0] port_rd_byte,
  output logic host_mode,
  output logic fifo_passive,
  output logic adc_enable,
  output logic dac_enable,
  output logic config_done
);
  typedef enum logic [1:0] {RCH_IDLE, RCH_DATA} rch_state_t;

  rch_state_t state_reg;
  logic [7:0] regs_reg [rch_pkg::NUM_REGS];
  logic [4:0] cmd_addr_reg;
  logic cmd_read_reg;
  logic [4:0] host_addr_reg;
  logic [7:0] sync1_reg [2];
  logic [7:0] sync2_reg [2];
  logic [7:0] bus_s;
  logic sel_n_s;
  logic wnr_s;
  logic dna_s;
  logic stb_s;
  logic stb_d_reg;
  logic stb_rise;
  logic [1:0] link_cnt_reg;

  // Two-stage synchronisers for host pins; select rests high so no false select after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg[0] <= rch_pkg::ZERO_BYTE;
      sync2_reg[0] <= rch_pkg::ZERO_BYTE;
      sync1_reg[1] <= rch_pkg::HOST_CTRL_RST;
      sync2_reg[1] <= rch_pkg::HOST_CTRL_RST;
    end else begin
      sync1_reg[0] <= host_bus_lines_in;
      sync1_reg[1] <= {4'h0, host_strobe, host_data_not_address, host_write_not_read, host_select_n};
      sync2_reg[0] <= sync1_reg[0];
      sync2_reg[1] <= sync1_reg[1];
    end
  end

  assign bus_s = sync2_reg[0];
  assign sel_n_s = sync2_reg[1][0];
  assign wnr_s = sync2_reg[1][1];
  assign dna_s = sync2_reg[1][2];
  assign stb_s = sync2_reg[1][3];
  assign stb_rise = stb_s & ~stb_d_reg & ~sel_n_s;

  // Strobe edge memory
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stb_d_reg <= 1'b0;
    end else begin
      stb_d_reg <= stb_s;
    end
  end

  function automatic logic is_port(input logic [4:0] a);
    return (a == rch_pkg::PORT_FIFO) || (a == rch_pkg::PORT_HOST) ||
           (a == rch_pkg::PORT_UART) || (a == rch_pkg::PORT_MEM);
  endfunction : is_port

  // Link command state: command byte then data bytes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RCH_IDLE;
      cmd_addr_reg <= '0;
      cmd_read_reg <= 1'b0;
      link_cnt_reg <= '0;
    end else begin
      case (state_reg)
        RCH_IDLE: begin
          if (link_valid) begin
            cmd_read_reg <= link_byte[rch_pkg::CMD_READ_BIT[2:0]];
            cmd_addr_reg <= link_byte[4:0];
            link_cnt_reg <= '0;
            if (!link_last) begin
              state_reg <= RCH_DATA;
            end
          end
        end
        RCH_DATA: begin
          if (link_valid) begin
            link_cnt_reg <= rch_pkg::CNT_ONE;
            if (link_last) begin
              state_reg <= RCH_IDLE;
            end
          end
        end
        default: state_reg <= RCH_IDLE;
      endcase
    end
  end

  logic link_wr;
  logic host_wr;
  assign link_wr = (state_reg == RCH_DATA) && link_valid && !cmd_read_reg &&
                   !(link_cnt_reg != '0 && !is_port(cmd_addr_reg));
  assign host_wr = stb_rise && wnr_s && dna_s;

  // Register file writes from link or host, link wins when both write in one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < rch_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= rch_pkg::ZERO_BYTE;
      end
      regs_reg[rch_pkg::REG_PIN_CFG] <= rch_pkg::PIN_CFG_RST;
    end else begin
      regs_reg[rch_pkg::REG_GPIO_IN] <= bus_s;
      if (link_wr && !is_port(cmd_addr_reg)) begin
        regs_reg[cmd_addr_reg] <= link_byte;
      end else if (host_wr && !is_port(host_addr_reg)) begin
        regs_reg[host_addr_reg] <= bus_s;
      end
    end
  end

  // Host address register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_addr_reg <= '0;
    end else if (stb_rise && wnr_s && !dna_s) begin
      host_addr_reg <= bus_s[4:0];
    end
  end

  logic [7:0] host_rd_val;
  assign host_rd_val = !dna_s ? {3'h0, host_addr_reg} :
                       is_port(host_addr_reg) ? port_rd_byte : regs_reg[host_addr_reg];

  // Port queue traffic: link data bytes go to or from the port; host writes too, unless a link port write takes that cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_wr_valid <= 1'b0;
      port_wr_sel <= '0;
      port_wr_byte <= '0;
      port_rd_req <= 1'b0;
      port_rd_sel <= '0;
    end else begin
      port_wr_valid <= 1'b0;
      port_rd_req <= 1'b0;
      if (link_wr && is_port(cmd_addr_reg)) begin
        port_wr_valid <= 1'b1;
        port_wr_sel <= cmd_addr_reg[1:0];
        port_wr_byte <= link_byte;
      end else if (host_wr && is_port(host_addr_reg)) begin
        port_wr_valid <= 1'b1;
        port_wr_sel <= host_addr_reg[1:0];
        port_wr_byte <= bus_s;
      end
      if (state_reg == RCH_DATA && link_valid && cmd_read_reg && is_port(cmd_addr_reg)) begin
        port_rd_req <= 1'b1;
        port_rd_sel <= cmd_addr_reg[1:0];
      end
    end
  end

  // Link read answers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_rd_valid <= 1'b0;
      link_rd_byte <= '0;
    end else begin
      link_rd_valid <= state_reg == RCH_DATA && link_valid && cmd_read_reg &&
                       !(link_cnt_reg != '0 && !is_port(cmd_addr_reg));
      link_rd_byte <= is_port(cmd_addr_reg) ? port_rd_byte : regs_reg[cmd_addr_reg];
    end
  end

  // Pins: host bus or GPIO, mode bits and interrupt
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_bus_lines_out <= '0;
      host_bus_lines_oe <= '0;
      host_mode <= 1'b1;
      fifo_passive <= 1'b0;
      adc_enable <= 1'b0;
      dac_enable <= 1'b0;
      config_done <= 1'b0;
      host_irq_n <= 1'b1;
    end else begin
      host_mode <= regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_HOST_EN];
      fifo_passive <= regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_FIFO_PASSIVE];
      adc_enable <= regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_ADC_EN] &
                    ~regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_FIFO_PASSIVE];
      dac_enable <= regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_DAC_EN] &
                    ~regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_FIFO_PASSIVE];
      config_done <= regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_CONF_DONE];
      host_irq_n <= (regs_reg[rch_pkg::REG_IRQ_SET] == rch_pkg::ZERO_BYTE);
      if (regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_HOST_EN]) begin
        host_bus_lines_out <= host_rd_val;
        host_bus_lines_oe <= {8{~sel_n_s & ~wnr_s}};
      end else begin
        host_bus_lines_out <= regs_reg[rch_pkg::REG_GPIO_OUT];
        host_bus_lines_oe <= regs_reg[rch_pkg::REG_GPIO_DIR];
      end
    end
  end

  property p_passive_blocks_adc;
    @(posedge clock) disable iff (!rst_n) fifo_passive |-> !adc_enable && !dac_enable;
  endproperty
  a_passive_blocks_adc: assert property (p_passive_blocks_adc) else $error("adc on in passive");

  property p_idle_no_drive;
    @(posedge clock) disable iff (!rst_n) (host_mode && sel_n_s) |=> host_bus_lines_oe == 8'h00 || !host_mode;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive) else $error("bus driven unselected");

  // Named steps of a link command
  sequence s_cmd_taken;
    state_reg == RCH_IDLE && link_valid && !link_last;
  endsequence
  sequence s_reg_surplus;
    state_reg == RCH_DATA && link_valid && link_cnt_reg != '0 && !is_port(cmd_addr_reg);
  endsequence
  sequence s_port_byte;
    link_wr && is_port(cmd_addr_reg);
  endsequence

  // Command byte opens data phase, msb picks read
  property p_cmd_direction;
    @(posedge clock) disable iff (!rst_n)
      s_cmd_taken |=> state_reg == RCH_DATA && cmd_read_reg == $past(link_byte[rch_pkg::CMD_READ_BIT[2:0]]);
  endproperty
  a_cmd_direction: assert property (p_cmd_direction) else $error("command direction wrong");

  // Surplus byte on a register address gets no answer
  property p_reg_one_byte;
    @(posedge clock) disable iff (!rst_n)
      s_reg_surplus |=> !link_rd_valid;
  endproperty
  a_reg_one_byte: assert property (p_reg_one_byte) else $error("register answered twice");

  // Every link data byte to a port reaches the port
  property p_port_write;
    @(posedge clock) disable iff (!rst_n)
      s_port_byte |=> port_wr_valid && port_wr_byte == $past(link_byte);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port byte lost");

  // Pending interrupt pulls request line low
  property p_irq_follows;
    @(posedge clock) disable iff (!rst_n)
      (regs_reg[rch_pkg::REG_IRQ_SET] != rch_pkg::ZERO_BYTE) |=> !host_irq_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq line not low");

  // Host port off: line drive follows direction register
  property p_gpio_dir;
    @(posedge clock) disable iff (!rst_n)
      !regs_reg[rch_pkg::REG_PIN_CFG][rch_pkg::CFG_HOST_EN] |=>
        host_bus_lines_oe == $past(regs_reg[rch_pkg::REG_GPIO_DIR]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");

  // Deselected host cannot move the address register
  property p_unselected_hold;
    @(posedge clock) disable iff (!rst_n)
      sel_n_s |=> $stable(host_addr_reg);
  endproperty
  a_unselected_hold: assert property (p_unselected_hold) else $error("address moved unselected");

  // Address strobe loads the address register
  property p_addr_capture;
    @(posedge clock) disable iff (!rst_n)
      (stb_rise && wnr_s && !dna_s) |=> host_addr_reg == $past(bus_s[4:0]);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address not captured");
endmodule : rch_core

// ### rch_host_model.sv
// Local host processor model on the multiplexed host port
`timescale 1ns/1ps
module rch_host_model (
  input wire logic clock,
  output logic host_select_n,
  output logic host_write_not_read,
  output logic host_data_not_address,
  output logic host_strobe,
  output logic [7:0] host_bus_lines_in,
  input wire logic [7:0] host_bus_lines_out,
  input wire logic [7:0] host_bus_lines_oe
);
  logic drv;
  logic [7:0] hd;
  // Wire level: device drive, else host drive, else pull-up
  assign host_bus_lines_in = (host_bus_lines_oe & host_bus_lines_out) | (~host_bus_lines_oe & (drv ? hd : 8'hff));
  // Idle: deselected, lines released
  initial begin
    host_select_n = 1'b1;
    host_write_not_read = 1'b0;
    host_data_not_address = 1'b0;
    host_strobe = 1'b0;
    drv = 1'b0;
    hd = 8'h00;
  end
  // One host transfer, qualifiers held around the strobe
  task hx(input logic s_n, input logic wnr, input logic dna, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    host_select_n = s_n;
    host_write_not_read = wnr;
    host_data_not_address = dna;
    drv = wnr;
    hd = d;
    repeat (3) @(posedge clock);
    #1;
    host_strobe = 1'b1;
    repeat (8) @(posedge clock);
    q = host_bus_lines_in;
    #1;
    host_strobe = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    host_select_n = 1'b1;
    drv = 1'b0;
  endtask : hx
endmodule : rch_host_model

// ### rch_pkg.sv
// Shared constants for the register command and host port block
package rch_pkg;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned AW = 5;
  localparam logic [7:0] CMD_READ_BIT = 8'h07;
  // Register index map
  localparam logic [4:0] REG_PIN_CFG = 5'h00;
  localparam logic [4:0] REG_GPIO_DIR = 5'h01;
  localparam logic [4:0] REG_GPIO_OUT = 5'h02;
  localparam logic [4:0] REG_GPIO_IN = 5'h03;
  localparam logic [4:0] REG_IRQ_SET = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h05;
  localparam logic [4:0] PORT_FIFO = 5'h10;
  localparam logic [4:0] PORT_HOST = 5'h11;
  localparam logic [4:0] PORT_UART = 5'h12;
  localparam logic [4:0] PORT_MEM = 5'h13;
  // Pin configuration fields
  localparam int unsigned CFG_HOST_EN = 0;
  localparam int unsigned CFG_FIFO_PASSIVE = 1;
  localparam int unsigned CFG_ADC_EN = 2;
  localparam int unsigned CFG_DAC_EN = 3;
  localparam int unsigned CFG_CONF_DONE = 4;
  localparam logic [7:0] PIN_CFG_RST = 8'h01;
  // Host control pins at rest: deselected, strobe low
  localparam logic [7:0] HOST_CTRL_RST = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] CNT_ONE = 2'h1;
endpackage : rch_pkg

// ### tb_top.sv
// Self-checking bench for the register command and host port core
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, rst_n = 0, link_valid = 0, link_last = 0, link_rd_valid;
  logic [7:0] link_byte = 0, link_rd_byte, port_rd_byte = 0, port_wr_byte, hbo, hboe, hbi, q, v, rd_last, wr_last;
  logic hsn, hwnr, hdna, hstb, irq_n, port_wr_valid, port_rd_req, hmode, fpas, adc, dac, cdone;
  logic [1:0] port_wr_sel, port_rd_sel, wsel;
  int n_fail = 0, num_checks = 0, seed = 14644, cyc = 0, nrd = 0, nwr = 0, nreq = 0, k, m;
  rch_core dut (.clock(clock), .rst_n(rst_n), .link_valid(link_valid), .link_byte(link_byte),
    .link_last(link_last), .link_rd_valid(link_rd_valid), .link_rd_byte(link_rd_byte),
    .host_select_n(hsn), .host_write_not_read(hwnr), .host_data_not_address(hdna), .host_strobe(hstb),
    .host_bus_lines_in(hbi), .host_bus_lines_out(hbo), .host_bus_lines_oe(hboe), .host_irq_n(irq_n),
    .port_wr_valid(port_wr_valid), .port_wr_sel(port_wr_sel), .port_wr_byte(port_wr_byte),
    .port_rd_req(port_rd_req), .port_rd_sel(port_rd_sel), .port_rd_byte(port_rd_byte), .host_mode(hmode),
    .fifo_passive(fpas), .adc_enable(adc), .dac_enable(dac), .config_done(cdone));
  rch_host_model hm (.clock(clock), .host_select_n(hsn), .host_write_not_read(hwnr),
    .host_data_not_address(hdna), .host_strobe(hstb), .host_bus_lines_in(hbi),
    .host_bus_lines_out(hbo), .host_bus_lines_oe(hboe));
  // Clock, watchdog and pulse monitors
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (link_rd_valid === 1'b1) begin
      nrd++;
      rd_last = link_rd_byte;
    end
    if (port_wr_valid === 1'b1) begin
      nwr++;
      wr_last = port_wr_byte;
      wsel = port_wr_sel;
    end
    if (port_rd_req === 1'b1) nreq++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One link byte, strobed for one edge
  task lb(input logic [7:0] b, input logic l);
    @(posedge clock);
    #1;
    link_valid = 1'b1;
    link_byte = b;
    link_last = l;
    @(posedge clock);
    #1;
    link_valid = 1'b0;
    link_last = 1'b0;
  endtask : lb
  task wr(input logic [4:0] a, input logic [7:0] d);
    lb({3'h0, a}, 1'b0);
    lb(d, 1'b1);
    repeat (3) @(posedge clock);
  endtask : wr
  task rd(input logic [4:0] a, output logic [7:0] d);
    m = nrd;
    lb({3'h4, a}, 1'b0);
    lb(8'h00, 1'b1);
    repeat (3) @(posedge clock);
    chk(8'(nrd - m), 8'h01);
    d = rd_last;
  endtask : rd
  // Expected pin-sharing levels from a config byte
  function logic [7:0] cfg_exp(input logic [7:0] c);
    return {3'h0, c[4], c[3] & ~c[1], c[2] & ~c[1], c[1], c[0]};
  endfunction : cfg_exp
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk({3'h0, cdone, dac, adc, fpas, hmode}, 8'h01);
    chk({7'h00, irq_n}, 8'h01);
    $display("test reset done");
    // Random round trips, then a refused surplus byte
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(i[0] ? rch_pkg::REG_GPIO_DIR : rch_pkg::REG_GPIO_OUT, v);
      rd(i[0] ? rch_pkg::REG_GPIO_DIR : rch_pkg::REG_GPIO_OUT, q);
      chk(q, v);
    end
    lb({3'h0, rch_pkg::REG_GPIO_OUT}, 1'b0);
    lb(8'h5a, 1'b0);
    lb(8'ha5, 1'b1);
    rd(rch_pkg::REG_GPIO_OUT, q);
    chk(q, 8'h5a);
    m = nrd;
    lb({3'h4, rch_pkg::REG_GPIO_OUT}, 1'b0);
    lb(8'h00, 1'b0);
    lb(8'h00, 1'b1);
    repeat (3) @(posedge clock);
    chk(8'(nrd - m), 8'h01);
    chk(rd_last, 8'h5a);
    $display("test registers done");
    // Packet write and packet read on ports
    k = nwr;
    lb({3'h0, rch_pkg::PORT_MEM}, 1'b0);
    for (int i = 0; i < 3; i++) lb(8'h30 + 8'(i), i == 2);
    repeat (3) @(posedge clock);
    chk(8'(nwr - k), 8'h03);
    chk(wr_last, 8'h32);
    chk({6'h00, wsel}, 8'h03);
    port_rd_byte = $random(seed);
    k = nreq;
    m = nrd;
    lb({3'h4, rch_pkg::PORT_UART}, 1'b0);
    lb(8'h00, 1'b0);
    lb(8'h00, 1'b1);
    repeat (3) @(posedge clock);
    chk(8'(nreq - k), 8'h02);
    chk(8'(nrd - m), 8'h02);
    chk(rd_last, port_rd_byte);
    $display("test ports done");
    wr(rch_pkg::REG_IRQ_SET, 8'h04);
    chk({7'h00, irq_n}, 8'h00);
    wr(rch_pkg::REG_IRQ_SET, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    $display("test irq done");
    wr(rch_pkg::REG_PIN_CFG, 8'h1f);
    chk({3'h0, cdone, dac, adc, fpas, hmode}, cfg_exp(8'h1f));
    wr(rch_pkg::REG_PIN_CFG, 8'h0d);
    chk({3'h0, cdone, dac, adc, fpas, hmode}, cfg_exp(8'h0d));
    $display("test pin config done");
    // Mid-run reset: pin sharing back to defaults, bus not driven
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk({3'h0, cdone, dac, adc, fpas, hmode}, 8'h01);
    @(posedge clock);
    #1;
    chk(hboe, 8'h00);
    $display("test mid reset done");
    // Host: address, data write, read back, deselected strobe
    hm.hx(1'b0, 1'b1, 1'b0, {3'h0, rch_pkg::REG_GPIO_DIR}, q);
    v = $random(seed);
    hm.hx(1'b0, 1'b1, 1'b1, v, q);
    rd(rch_pkg::REG_GPIO_DIR, q);
    chk(q, v);
    hm.hx(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk(q, v);
    hm.hx(1'b1, 1'b1, 1'b1, ~v, q);
    rd(rch_pkg::REG_GPIO_DIR, q);
    chk(q, v);
    $display("test host done");
    // Host disabled: lines serve as GPIO
    wr(rch_pkg::REG_PIN_CFG, 8'h00);
    wr(rch_pkg::REG_GPIO_DIR, 8'hff);
    v = $random(seed);
    wr(rch_pkg::REG_GPIO_OUT, v);
    chk(hboe, 8'hff);
    chk(hbo, v);
    wr(rch_pkg::REG_GPIO_DIR, 8'h00);
    repeat (4) @(posedge clock);
    rd(rch_pkg::REG_GPIO_IN, q);
    chk(q, 8'hff);
    #1;
    v = $random(seed);
    hm.hd = v;
    hm.drv = 1'b1;
    repeat (4) @(posedge clock);
    rd(rch_pkg::REG_GPIO_IN, q);
    chk(q, v);
    #1;
    hm.drv = 1'b0;
    $display("test gpio done");
    tally_and_finish();
  end
endmodule : tb_top
